// file: verilog/art_pkg.sv
`default_nettype none
package art_pkg;

  // Byte-wide register map.
  localparam logic [7:0] ADDR_TIMER_CONTROL_STATUS = 8'h0D;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h0E;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'h0F;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h11;
  localparam logic [7:0] ADDR_PWM_OUTPUT_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_PWM_CONTROL_STATUS = 8'h13;
  localparam logic [7:0] ADDR_DUTY_HIGH = 8'h17;
  localparam logic [7:0] ADDR_DUTY_LOW = 8'h18;

  // Field positions in the timer control/status byte.
  localparam int POS_CLOCK_SELECT_LSB = 3;
  localparam int POS_OVERFLOW_FLAG = 2;
  localparam int POS_OVERFLOW_IRQ_ENABLE = 1;
  localparam int POS_COMPARE_IRQ_ENABLE = 0;
  // Field positions in the PWM control/status and output control bytes.
  localparam int POS_OUTPUT_POLARITY = 1;
  localparam int POS_COMPARE_FLAG = 0;
  localparam int POS_PIN_OUTPUT_ENABLE = 0;

  // Reset values and the counter maximum.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] RESET_COUNT = 12'h000;
  localparam logic [11:0] COUNT_MAX = 12'hFFF;

  // Counter clock source codes.
  localparam logic [1:0] CLOCK_OFF = 2'h0;
  localparam logic [1:0] CLOCK_TIMEBASE = 2'h1;
  localparam logic [1:0] CLOCK_CPU = 2'h2;
  localparam logic [1:0] CLOCK_RESERVED = 2'h3;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } art_bus_req_t;

endpackage : art_pkg
`default_nettype wire

// file: verilog/art_timer.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Clock select: 00 stops, 01 timebase ticks, 10 CPU clock, 11 reserved.
// - A new clock select value takes effect at the next overflow, or at once while the counter is stopped (off or reserved).
// - Overflow flag sets on wrap from maximum; reading timer control/status clears it.
// - Overflow flag stays set until the next counter tick or a status read; a stopped counter leaves it set.
// - Overflow interrupt request follows the flag only while its enable is one.
// - Compare interrupt request follows the compare flag only while its enable is one.
// - Read-only 12-bit counter resets to zero and counts each enabled tick.
// - On overflow the counter reloads from the reload value, not zero.
// - Reload value is a writable 12-bit register split into two bytes.
// - Output enable set means PWM duty; clear means output compare on duty value.
// - Polarity bit one inverts the PWM output; reset clears it.
// - Compare flag sets when counter equals compare value; reading PWM status clears it.
// - Output enable clear frees the pin; set drives the PWM signal.
// - Reserved register bits read back as zero.
// - Every register holds zero after reset.
// - Overflow in PWM mode loads shadow duty and drives high; match drives low.
// - Duty high write locks all compares until the duty low write.
// - In output compare mode a written duty value applies at once.
// - Compare stays inactive while the compare value is zero.
module art_timer
  import art_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port.
  input wire art_bus_req_t busReq,
  output logic [7:0] rdData,
  // Timebase tick from the lite timer, one cycle per timebase period.
  input wire logic timebaseTick,
  // Pin and interrupt requests.
  output logic pwmOutputPin,
  output logic pwmPinEnable,
  output logic overflowIrq,
  output logic compareIrq
);

  // Software-visible state.
  logic [1:0] counterClockSelect;
  logic overflowIrqEnable;
  logic compareIrqEnable;
  logic overflowFlag;
  logic [11:0] reloadValue;
  logic pinOutputEnable;
  logic outputPolarity;
  logic compareFlag;
  logic [3:0] dutyHigh;
  logic [7:0] dutyLow;
  // Internal state.
  logic [1:0] activeClock;
  logic [11:0] counterValue;
  logic [3:0] counterHighCapture;
  logic [11:0] dutyShadow;
  logic compareLocked;
  logic pwmLevel;

  // Address decode.
  wire logic selCsr = busReq.addr == ADDR_TIMER_CONTROL_STATUS;
  wire logic selCntH = busReq.addr == ADDR_COUNTER_HIGH;
  wire logic selCntL = busReq.addr == ADDR_COUNTER_LOW;
  wire logic selRelH = busReq.addr == ADDR_RELOAD_HIGH;
  wire logic selRelL = busReq.addr == ADDR_RELOAD_LOW;
  wire logic selPwmCr = busReq.addr == ADDR_PWM_OUTPUT_CONTROL;
  wire logic selPwmCsr = busReq.addr == ADDR_PWM_CONTROL_STATUS;
  wire logic selDutyH = busReq.addr == ADDR_DUTY_HIGH;
  wire logic selDutyL = busReq.addr == ADDR_DUTY_LOW;

  wire logic wrCsr = busReq.write && selCsr;
  wire logic wrRelH = busReq.write && selRelH;
  wire logic wrRelL = busReq.write && selRelL;
  wire logic wrPwmCr = busReq.write && selPwmCr;
  wire logic wrPwmCsr = busReq.write && selPwmCsr;
  wire logic wrDutyH = busReq.write && selDutyH;
  wire logic wrDutyL = busReq.write && selDutyL;
  wire logic rdCsr = busReq.read && selCsr;
  wire logic rdCntL = busReq.read && selCntL;
  wire logic rdPwmCsr = busReq.read && selPwmCsr;

  // Counter clock enable; the reserved code behaves like off.
  wire logic tick = (activeClock == CLOCK_CPU) ||
                    ((activeClock == CLOCK_TIMEBASE) && timebaseTick);
  wire logic atMax = counterValue == COUNT_MAX;
  wire logic overflowEvent = tick && atMax;
  wire logic [11:0] next_counterValue = overflowEvent ? reloadValue :
                                        (counterValue + 12'h001);

  // The shadow follows the duty bytes at every overflow, even mid-update.
  wire logic [11:0] dutyValue = {dutyHigh, dutyLow};
  wire logic [11:0] next_dutyShadow = overflowEvent ? dutyValue : dutyShadow;
  // PWM mode compares against the shadow, compare mode against the live value.
  wire logic [11:0] compareValue = pinOutputEnable ? next_dutyShadow : dutyValue;
  // The match is taken on the tick that brings the counter onto the value.
  wire logic matchEvent = tick && !compareLocked && (compareValue != 12'h000) &&
                          (next_counterValue == compareValue);

  // A stopped counter cannot overflow, so a select written while stopped,
  // whether off or on the reserved code, is applied at once; otherwise the
  // counter could never be started again.
  wire logic counterRunning = (activeClock == CLOCK_CPU) || (activeClock == CLOCK_TIMEBASE);
  wire logic applyClock = overflowEvent || !counterRunning;

  // Read data selection; unmapped addresses and reserved bits read as zero.
  wire logic [7:0] csrByte = {3'h0, counterClockSelect, overflowFlag,
                              overflowIrqEnable, compareIrqEnable};
  wire logic [7:0] next_rdData =
      selCsr ? csrByte :
      selCntH ? {4'h0, counterHighCapture} :
      selCntL ? counterValue[7:0] :
      selRelH ? {4'h0, reloadValue[11:8]} :
      selRelL ? reloadValue[7:0] :
      selPwmCr ? {7'h00, pinOutputEnable} :
      selPwmCsr ? {6'h00, outputPolarity, compareFlag} :
      selDutyH ? {4'h0, dutyHigh} :
      selDutyL ? dutyLow : RESET_BYTE;

  // Register port: read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdData <= RESET_BYTE;
    end else begin
      rdData <= busReq.read ? next_rdData : RESET_BYTE;
    end
  end

  // Timer control bits.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      counterClockSelect <= CLOCK_OFF;
      overflowIrqEnable <= 1'b0;
      compareIrqEnable <= 1'b0;
      activeClock <= CLOCK_OFF;
    end else begin
      if (wrCsr) begin
        counterClockSelect <= busReq.wdata[POS_CLOCK_SELECT_LSB +: 2];
        overflowIrqEnable <= busReq.wdata[POS_OVERFLOW_IRQ_ENABLE];
        compareIrqEnable <= busReq.wdata[POS_COMPARE_IRQ_ENABLE];
      end
      if (applyClock) begin
        activeClock <= counterClockSelect;
      end
    end
  end

  // Overflow flag: set wins over both the read clear and the next tick.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      overflowFlag <= 1'b0;
    end else if (overflowEvent) begin
      overflowFlag <= 1'b1;
    end else if (rdCsr || tick) begin
      overflowFlag <= 1'b0;
    end
  end

  // Counter and its high-byte capture.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      counterValue <= RESET_COUNT;
      counterHighCapture <= 4'h0;
    end else begin
      if (tick) begin
        counterValue <= next_counterValue;
      end
      if (rdCntL) begin
        counterHighCapture <= counterValue[11:8];
      end
    end
  end

  // Reload value and output control.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reloadValue <= RESET_COUNT;
      pinOutputEnable <= 1'b0;
      outputPolarity <= 1'b0;
    end else begin
      if (wrRelH) begin
        reloadValue[11:8] <= busReq.wdata[3:0];
      end
      if (wrRelL) begin
        reloadValue[7:0] <= busReq.wdata;
      end
      if (wrPwmCr) begin
        pinOutputEnable <= busReq.wdata[POS_PIN_OUTPUT_ENABLE];
      end
      if (wrPwmCsr) begin
        outputPolarity <= busReq.wdata[POS_OUTPUT_POLARITY];
      end
    end
  end

  // Duty bytes and the lock between the high and the low write.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dutyHigh <= 4'h0;
      dutyLow <= RESET_BYTE;
      dutyShadow <= RESET_COUNT;
      compareLocked <= 1'b0;
    end else begin
      dutyShadow <= next_dutyShadow;
      if (wrDutyH) begin
        dutyHigh <= busReq.wdata[3:0];
        compareLocked <= 1'b1;
      end
      if (wrDutyL) begin
        dutyLow <= busReq.wdata;
        compareLocked <= 1'b0;
      end
    end
  end

  // Compare flag: a match in the cycle of the clearing read is kept.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      compareFlag <= 1'b0;
    end else if (matchEvent) begin
      compareFlag <= 1'b1;
    end else if (rdPwmCsr) begin
      compareFlag <= 1'b0;
    end
  end

  // PWM waveform. When duty equals reload the match beats the overflow,
  // giving a constant low that the polarity bit can turn into full duty.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pwmLevel <= 1'b0;
    end else if (matchEvent && pinOutputEnable) begin
      pwmLevel <= 1'b0;
    end else if (overflowEvent) begin
      pwmLevel <= 1'b1;
    end
  end

  assign pwmPinEnable = pinOutputEnable;
  assign pwmOutputPin = pinOutputEnable && (pwmLevel ^ outputPolarity);
  assign overflowIrq = overflowFlag && overflowIrqEnable;
  assign compareIrq = compareFlag && compareIrqEnable;

  chk_clock_apply_overflow: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    counterRunning && !overflowEvent |=> $stable(activeClock))
    else $error("clock source changed without an overflow");

  chk_overflow_wraps_reload: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    overflowEvent |=> (counterValue == $past(reloadValue)) && overflowFlag)
    else $error("overflow did not reload the counter or set the flag");

  chk_overflow_one_period: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    overflowFlag && tick && !overflowEvent |=> !overflowFlag)
    else $error("overflow flag outlived one counter period");

  chk_counter_stopped: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (activeClock == CLOCK_OFF) || (activeClock == CLOCK_RESERVED) |=> $stable(counterValue))
    else $error("counter moved with no clock source");

  chk_counter_increments: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (activeClock == CLOCK_CPU) && !atMax |=> counterValue == $past(counterValue) + 12'h001)
    else $error("counter failed to count on the CPU clock");

  chk_irq_overflow_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    overflowEvent && overflowIrqEnable && !wrCsr |=> overflowIrq)
    else $error("enabled overflow raised no request");

  chk_lock_no_compare: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wrDutyH && !wrDutyL ##1 (compareLocked && !wrDutyL) [*2] |-> !matchEvent)
    else $error("compare fired while the duty update was open");

  chk_zero_no_flag: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !compareFlag && (compareValue == 12'h000) |=> !compareFlag)
    else $error("compare flag raised for a zero compare value");

  chk_flag_read_clear: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rdPwmCsr && !matchEvent |=> !compareFlag ##0 rdData[POS_COMPARE_FLAG] == $past(compareFlag))
    else $error("compare flag read clear misbehaved");

  chk_pin_released: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !pinOutputEnable |-> !pwmOutputPin && !pwmPinEnable)
    else $error("pin driven with output disabled");

  chk_pwm_high_overflow: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    overflowEvent && pinOutputEnable && !matchEvent |=> pwmOutputPin == !outputPolarity)
    else $error("PWM output not raised at overflow");

  chk_high_capture: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rdCntL ##1 (busReq.read && selCntH) |=> rdData[3:0] == $past(counterValue[11:8], 2))
    else $error("counter high byte not consistent with low byte");

  chk_read_clears_overflow: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    rdCsr && !overflowEvent |=> !overflowFlag)
    else $error("overflow flag survived a status read");

  chk_compare_irq_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    matchEvent && compareIrqEnable && !wrCsr |=> compareIrq)
    else $error("enabled compare raised no request");

  chk_duty_high_locks: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    wrDutyH |=> compareLocked)
    else $error("duty high write did not lock the compare");

  chk_shadow_at_overflow: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    overflowEvent |=> dutyShadow == $past(dutyValue))
    else $error("shadow duty not loaded at overflow");

  chk_compare_live_value: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    matchEvent && !pinOutputEnable |=> counterValue == $past(dutyValue))
    else $error("output compare did not use the live duty value");

  chk_pwm_low_match: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    matchEvent && pinOutputEnable && !wrPwmCr |=> pwmOutputPin == outputPolarity)
    else $error("PWM output not lowered at the match");

  chk_reset_clears_all: assert property (
    @(posedge clk_sys)
    !resetn |=> (counterValue == RESET_COUNT) && (rdData == RESET_BYTE) &&
                !overflowIrq && !compareIrq && !pwmPinEnable)
    else $error("state not cleared by reset");

  chk_timebase_stall: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (activeClock == CLOCK_TIMEBASE) && !timebaseTick |=> $stable(counterValue))
    else $error("counter moved without a timebase tick");

  chk_reserved_high_nibble: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    busReq.read && (selCntH || selRelH || selDutyH) |=> rdData[7:4] == 4'h0)
    else $error("reserved high bits read back nonzero");

endmodule : art_timer
`default_nettype wire

// file: verification/art_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module art_timer_tb
  import art_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  art_bus_req_t busReq = '0;
  logic timebaseTick = 1'b0;
  logic [7:0] rdData;
  logic pwmOutputPin;
  logic pwmPinEnable;
  logic overflowIrq;
  logic compareIrq;
  logic [7:0] expQ[$];
  logic [7:0] expV;
  logic rdSeen = 1'b0;
  logic [31:0] rnd = 32'h8223;
  int nFail = 0;
  int testsRun = 0;
  // The last two places are unmapped and must read as zero.
  logic [7:0] regAddr [11] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h18,
                               8'h14, 8'h16};

  always #5 clk_sys = ~clk_sys;

  art_timer dut_u (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .busReq(busReq),
    .rdData(rdData),
    .timebaseTick(timebaseTick),
    .pwmOutputPin(pwmOutputPin),
    .pwmPinEnable(pwmPinEnable),
    .overflowIrq(overflowIrq),
    .compareIrq(compareIrq)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Levels are taken when the check is called, before that edge's updates land.
  task automatic chk(input logic got, input logic exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: %s is %b", $time, msg, got);
    end
    @(posedge clk_sys);
  endtask : chk

  // Bus tasks leave the strobe up so back-to-back cycles need no gap; cyc drops it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    busReq <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
  endtask : rd

  task automatic cyc(input int n);
    busReq <= '0;
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wait_ovf(input int lim);
    int k;
    k = 0;
    busReq <= '0;
    while (overflowIrq !== 1'b1 && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    testsRun++;
    if (k >= lim) begin
      nFail++;
      $display("Error at %0t: no overflow request", $time);
      complete_run();
    end
    @(posedge clk_sys);
  endtask : wait_ovf

  task automatic count_high(input int n, input int e);
    int k;
    k = 0;
    busReq <= '0;
    repeat (n) begin
      @(negedge clk_sys);
      if (pwmOutputPin === 1'b1) begin
        k++;
      end
    end
    testsRun++;
    if (k != e) begin
      nFail++;
      $display("Error at %0t: pin high %0d cycles, expected %0d", $time, k, e);
    end
    @(posedge clk_sys);
  endtask : count_high

  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge clk_sys) begin
    if (rdSeen === 1'b1) begin
      testsRun++;
      expV = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
      if (rdData !== expV) begin
        nFail++;
        $display("Error at %0t: read %h, expected %h", $time, rdData, expV);
      end
    end else if (resetn === 1'b1 && rdData !== RESET_BYTE) begin
      nFail++;
      $display("Error at %0t: read data %h outside a read cycle", $time, rdData);
    end
    rdSeen <= busReq.read;
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (regAddr[i]) rd(regAddr[i], RESET_BYTE);
    cyc(1);
    chk(pwmPinEnable, 1'b0, "pin enable");
    chk(overflowIrq | compareIrq, 1'b0, "irq after reset");
    rnd = lfsr_next(rnd);
    wr(ADDR_RELOAD_HIGH, 8'hFF);
    rd(ADDR_RELOAD_HIGH, 8'h0F);
    wr(ADDR_RELOAD_LOW, rnd[7:0]);
    rd(ADDR_RELOAD_LOW, rnd[7:0]);
    wr(ADDR_DUTY_HIGH, 8'hFF);
    rd(ADDR_DUTY_HIGH, 8'h0F);
    wr(ADDR_DUTY_LOW, rnd[15:8]);
    rd(ADDR_DUTY_LOW, rnd[15:8]);
    wr(ADDR_PWM_OUTPUT_CONTROL, 8'hFF);
    rd(ADDR_PWM_OUTPUT_CONTROL, 8'h01);
    wr(ADDR_PWM_CONTROL_STATUS, 8'hFF);
    rd(ADDR_PWM_CONTROL_STATUS, 8'h02);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'hE7);
    rd(ADDR_TIMER_CONTROL_STATUS, 8'h03);
    wr(ADDR_COUNTER_LOW, 8'hFF);
    wr(ADDR_COUNTER_HIGH, 8'hFF);
    rd(ADDR_COUNTER_LOW, 8'h00);
    rd(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h00);
    wr(ADDR_PWM_OUTPUT_CONTROL, 8'h00);
    wr(ADDR_PWM_CONTROL_STATUS, 8'h00);
    wr(ADDR_DUTY_HIGH, 8'h00);
    wr(ADDR_DUTY_LOW, 8'h00);
    wr(ADDR_RELOAD_HIGH, 8'h0F);
    wr(ADDR_RELOAD_LOW, 8'hFA);
    // Start on the CPU clock, then ask for off: it must wait for the overflow.
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h12);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h02);
    wait_ovf(5000);
    cyc(3);
    rd(ADDR_COUNTER_LOW, 8'hFA);
    rd(ADDR_COUNTER_HIGH, 8'h0F);
    rd(ADDR_TIMER_CONTROL_STATUS, 8'h06);
    rd(ADDR_TIMER_CONTROL_STATUS, 8'h02);
    cyc(1);
    chk(overflowIrq, 1'b0, "overflow request");
    wr(ADDR_DUTY_HIGH, 8'h0F);
    wr(ADDR_DUTY_LOW, 8'hFC);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h11);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h01);
    cyc(20);
    chk(compareIrq, 1'b1, "compare request");
    chk(overflowIrq, 1'b0, "masked overflow request");
    rd(ADDR_PWM_CONTROL_STATUS, 8'h01);
    cyc(1);
    chk(compareIrq, 1'b0, "compare request");
    wr(ADDR_DUTY_HIGH, 8'h0F);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h11);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h01);
    cyc(20);
    rd(ADDR_PWM_CONTROL_STATUS, 8'h00);
    wr(ADDR_DUTY_LOW, 8'hFC);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h11);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h01);
    cyc(20);
    rd(ADDR_PWM_CONTROL_STATUS, 8'h01);
    // Period 4096 - 0xFFA = 6 ticks, high from reload until the count meets 0xFFC.
    wr(ADDR_PWM_OUTPUT_CONTROL, 8'h01);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h10);
    cyc(14);
    chk(pwmPinEnable, 1'b1, "pin enable");
    count_high(60, 20);
    wr(ADDR_PWM_CONTROL_STATUS, 8'h02);
    cyc(12);
    count_high(60, 40);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h00);
    cyc(20);
    wr(ADDR_PWM_OUTPUT_CONTROL, 8'h00);
    cyc(1);
    chk(pwmPinEnable | pwmOutputPin, 1'b0, "released pin");
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h08);
    cyc(10);
    rd(ADDR_COUNTER_LOW, 8'hFA);
    cyc(1);
    repeat (5) begin
      rnd = lfsr_next(rnd);
      timebaseTick <= 1'b1;
      @(posedge clk_sys);
      timebaseTick <= 1'b0;
      cyc(int'(rnd[2:0]) + 1);
    end
    rd(ADDR_COUNTER_LOW, 8'hFF);
    rd(ADDR_COUNTER_HIGH, 8'h0F);
    // The reserved code is taken at the next overflow and then holds the count.
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h18);
    timebaseTick <= 1'b1;
    cyc(3);
    timebaseTick <= 1'b0;
    rd(ADDR_COUNTER_LOW, 8'hFA);
    rd(ADDR_TIMER_CONTROL_STATUS, 8'h1C);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h12);
    wr(ADDR_TIMER_CONTROL_STATUS, 8'h02);
    wait_ovf(50);
    rd(ADDR_COUNTER_LOW, 8'hFA);
    cyc(2);
    complete_run();
  end
endmodule : art_timer_tb
`default_nettype wire
